// ---- core/scsbp_params.svh ----
// offsets, field positions, reset values and codes of the clock select block
// assumes a 32-bit register bus with byte addresses of SCSBP_ADDR_W bits
`ifndef SCSBP_PARAMS_SVH
`define SCSBP_PARAMS_SVH

`define SCSBP_ADDR_W 8
`define SCSBP_CFG1_OFF 8'h04
`define SCSBP_MON_OFF 8'h40
`define SCSBP_CFG1_RST 32'h0000_0000
`define SCSBP_MON_RST 32'h0000_0000
`define SCSBP_CFG_W 11
`define SCSBP_SEL_LSB 0
`define SCSBP_STAT_LSB 2
`define SCSBP_HDIV_LSB 4
`define SCSBP_LDIV_LSB 8
`define SCSBP_MON_EN_BIT 0
`define SCSBP_SRC_RC 2'h0
`define SCSBP_SRC_EXT 2'h1
`define SCSBP_SRC_SYNTH 2'h2
`define SCSBP_SRC_NONE 2'h3
`define SCSBP_HDIV_LOW_BASE 4'h1
`define SCSBP_HDIV_HIGH_BASE 4'h6
`define SCSBP_LDIV_BASE 4'h1
`define SCSBP_RESP_OKAY 2'h0
`define SCSBP_RESP_SLVERR 2'h2

`endif

// ---- core/scsbp_pkg.sv ----
// types shared by the clock select block
// assumes scsbp_params.svh supplies all numeric constants
package scsbp_pkg;

  // layout of the configuration word, bits 10:0
  typedef struct packed {
    logic [2:0] low_speed_bus_divider;
    logic [3:0] host_bus_divider;
    logic [1:0] core_clock_source_status;
    logic [1:0] core_clock_source_select;
  } scsbp_cfg_t;

  typedef enum logic [2:0] {
    SW_IDLE = 3'h1,
    SW_DRAIN = 3'h2,
    SW_LAND = 3'h4
  } scsbp_sw_t;

endpackage

// ---- core/scsbp_tick_div.sv ----
// power-of-two tick divider: one tick every 2**shift steps
// assumes shift stays below CNT_W+1; a shift change keeps the running count
`timescale 1ns/10ps
module scsbp_tick_div
  import scsbp_pkg::*;
#(
  parameter int CNT_W = 9,
  parameter int SH_W = 4
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic step,
  input wire logic [SH_W-1:0] shift,
  // divided tick
  output logic tick_q
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] mask;

  assign mask = ~({CNT_W{1'b1}} << shift);

  // the >= keeps a shrinking ratio from running the counter past its mask
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= '0;
    else if (step)
      cnt_q <= (cnt_q >= mask) ? '0 : cnt_q + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_q <= 1'b0;
    else
      tick_q <= step && (cnt_q >= mask);
  end

endmodule

// ---- core/scsbp_top.sv ----
// core clock source select with host and low-speed bus dividers
// assumes aclk stands for the core clock and the bus clocks are tick enables
`timescale 1ns/10ps
`include "scsbp_params.svh"
module scsbp_top
  import scsbp_pkg::*;
#(
  parameter int ADDR_W = `SCSBP_ADDR_W
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data and response
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // clock events, pins from outside this clock domain
  input wire logic low_power_exit,
  input wire logic ext_osc_fail,
  // synth reference is the external oscillator, same clock domain
  input wire logic synth_from_ext,
  // clock steering
  output logic [1:0] core_clock_source,
  output logic host_bus_tick,
  output logic low_speed_bus_tick
);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // macro literals cannot be part-selected, so they are named here first
  localparam logic [ADDR_W-1:0] CFG_ADDR = ADDR_W'(`SCSBP_CFG1_OFF);
  localparam logic [ADDR_W-1:0] MON_ADDR = ADDR_W'(`SCSBP_MON_OFF);
  localparam logic [31:0] CFG_RST = `SCSBP_CFG1_RST;
  localparam logic [31:0] MON_RST = `SCSBP_MON_RST;

  logic [1:0] sel_q;
  logic [1:0] stat_q;
  logic [3:0] hdiv_q;
  logic [2:0] ldiv_q;
  logic mon_en_q;
  scsbp_sw_t state_q;
  scsbp_cfg_t cfg_rd;
  logic aw_full_q, w_full_q, ar_full_q;
  logic awready_q, wready_q, arready_q;
  logic [ADDR_W-1:0] aw_addr_q, ar_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic fail_m_q, fail_s_q, wake_m_q, wake_s_q, wake_d_q;
  logic idle, do_wr, do_rd, wr_cfg, wr_mon, wake_ev, ext_feeds, fall_ev;
  logic [3:0] host_shift, low_shift;
  logic host_tick_q, low_tick_q;

  assign awready = awready_q;
  assign wready = wready_q;
  assign arready = arready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign core_clock_source = stat_q;
  assign host_bus_tick = host_tick_q;
  assign low_speed_bus_tick = low_tick_q;

  // pin synchronisers; the second stage is read, and wake also reads a third stage for its edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fail_m_q <= 1'b0;
      fail_s_q <= 1'b0;
      wake_m_q <= 1'b0;
      wake_s_q <= 1'b0;
      wake_d_q <= 1'b0;
    end
    else
    begin
      fail_m_q <= ext_osc_fail;
      fail_s_q <= fail_m_q;
      wake_m_q <= low_power_exit;
      wake_s_q <= wake_m_q;
      wake_d_q <= wake_s_q;
    end
  end

  assign wake_ev = wake_s_q && !wake_d_q;
  assign ext_feeds = (stat_q == `SCSBP_SRC_EXT)
    || (stat_q == `SCSBP_SRC_SYNTH && synth_from_ext);
  assign fall_ev = wake_ev || (fail_s_q && mon_en_q && ext_feeds);

  // bus requests wait while the source switch runs, at most two cycles
  assign idle = (state_q == SW_IDLE);
  assign do_wr = aw_full_q && w_full_q && !bvalid_q && idle;
  assign do_rd = ar_full_q && !rvalid_q && idle;
  assign wr_cfg = do_wr
    && (aw_addr_q[ADDR_W-1:2] == CFG_ADDR[ADDR_W-1:2]);
  assign wr_mon = do_wr
    && (aw_addr_q[ADDR_W-1:2] == MON_ADDR[ADDR_W-1:2]);

  // address and data channels are taken independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (awvalid && awready_q)
    begin
      aw_full_q <= 1'b1;
      awready_q <= 1'b0;
      aw_addr_q <= awaddr;
    end
    else
    begin
      if (do_wr)
        aw_full_q <= 1'b0;
      if (!aw_full_q)
        awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_q <= 1'b0;
      wready_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (wvalid && wready_q)
    begin
      w_full_q <= 1'b1;
      wready_q <= 1'b0;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end
    else
    begin
      if (do_wr)
        w_full_q <= 1'b0;
      if (!w_full_q)
        wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ar_full_q <= 1'b0;
      arready_q <= 1'b0;
      ar_addr_q <= '0;
    end
    else if (arvalid && arready_q)
    begin
      ar_full_q <= 1'b1;
      arready_q <= 1'b0;
      ar_addr_q <= araddr;
    end
    else
    begin
      if (do_rd)
        ar_full_q <= 1'b0;
      if (!ar_full_q)
        arready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `SCSBP_RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_cfg || wr_mon) ? `SCSBP_RESP_OKAY : `SCSBP_RESP_SLVERR;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  assign cfg_rd = '{low_speed_bus_divider: ldiv_q,
    host_bus_divider: hdiv_q, core_clock_source_status: stat_q,
    core_clock_source_select: sel_q};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= `SCSBP_RESP_OKAY;
      rdata_q <= '0;
    end
    else if (do_rd)
    begin
      rvalid_q <= 1'b1;
      if (ar_addr_q[ADDR_W-1:2] == CFG_ADDR[ADDR_W-1:2])
      begin
        rresp_q <= `SCSBP_RESP_OKAY;
        rdata_q <= {21'h00_0000, cfg_rd};
      end
      else if (ar_addr_q[ADDR_W-1:2] == MON_ADDR[ADDR_W-1:2])
      begin
        rresp_q <= `SCSBP_RESP_OKAY;
        rdata_q <= {31'h0000_0000, mon_en_q};
      end
      else
      begin
        rresp_q <= `SCSBP_RESP_SLVERR;
        rdata_q <= '0;
      end
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end

  // forced fallback beats a software write in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sel_q <= CFG_RST[1:0];
    else if (fall_ev)
      sel_q <= `SCSBP_SRC_RC;
    else if (wr_cfg && w_strb_q[0] && w_data_q[1:0] != `SCSBP_SRC_NONE)
      sel_q <= w_data_q[1:0];
  end

  // byte lanes let half-word and byte writes touch only their fields
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hdiv_q <= CFG_RST[7:4];
      ldiv_q <= CFG_RST[10:8];
    end
    else if (wr_cfg)
    begin
      if (w_strb_q[0])
        hdiv_q <= w_data_q[`SCSBP_HDIV_LSB +: 4];
      if (w_strb_q[1])
        ldiv_q <= w_data_q[`SCSBP_LDIV_LSB +: 3];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mon_en_q <= MON_RST[0];
    else if (wr_mon && w_strb_q[0])
      mon_en_q <= w_data_q[`SCSBP_MON_EN_BIT];
  end

  // two-cycle glitch-free handover: drain old source, land on new one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= SW_IDLE;
    else
      case (state_q)
        SW_IDLE:
          if (sel_q != stat_q)
            state_q <= SW_DRAIN;
        SW_DRAIN:
          state_q <= SW_LAND;
        SW_LAND:
          state_q <= SW_IDLE;
        default:
          state_q <= SW_IDLE;
      endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stat_q <= CFG_RST[3:2];
    else if (state_q == SW_LAND)
      stat_q <= sel_q;
  end

  always_comb
  begin
    if (!hdiv_q[3])
      host_shift = 4'h0;
    else if (!hdiv_q[2])
      host_shift = `SCSBP_HDIV_LOW_BASE + {2'h0, hdiv_q[1:0]};
    else
      host_shift = `SCSBP_HDIV_HIGH_BASE + {2'h0, hdiv_q[1:0]};
  end

  always_comb
  begin
    if (!ldiv_q[2])
      low_shift = 4'h0;
    else
      low_shift = `SCSBP_LDIV_BASE + {2'h0, ldiv_q[1:0]};
  end

  scsbp_tick_div #(.CNT_W(9), .SH_W(4)) host_div_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .step(1'b1),
    .shift(host_shift),
    .tick_q(host_tick_q)
  );

  scsbp_tick_div #(.CNT_W(4), .SH_W(4)) low_div_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .step(host_tick_q),
    .shift(low_shift),
    .tick_q(low_tick_q)
  );

  reset_clear_a: assert property (
    $past(!aresetn) |-> sel_q == 2'h0 && stat_q == 2'h0
      && hdiv_q == 4'h0 && ldiv_q == 3'h0)
    else $error("configuration not cleared by reset");
  write_answer_a: assert property (
    aw_full_q && w_full_q && !bvalid_q |-> ##[1:3] bvalid_q)
    else $error("write answer later than two waits");
  read_nowait_a: assert property (
    ar_full_q && !rvalid_q && idle |=> rvalid_q && !$past(rvalid_q))
    else $error("read waited without a switch");
  switch_hold_a: assert property (
    !idle && !bvalid_q && !rvalid_q |=> !bvalid_q && !rvalid_q)
    else $error("access completed during a switch");
  select_valid_a: assert property (
    sel_q != 2'h3)
    else $error("invalid select code stored");
  forced_rc_a: assert property (
    fall_ev |=> sel_q == 2'h0)
    else $error("fallback did not force rc source");
  monitor_off_a: assert property (
    fail_s_q && !mon_en_q && !wake_ev && !wr_cfg |=> $stable(sel_q))
    else $error("fallback taken with monitor disabled");
  status_lag_a: assert property (
    $changed(stat_q) |-> $past(state_q) == SW_LAND && stat_q != 2'h3)
    else $error("status changed outside switch end");
  host_pass_a: assert property (
    (host_shift == 4'h0 && $past(aresetn)) [*2] |-> host_tick_q)
    else $error("undivided host tick missing");
  host_half_a: assert property (
    (hdiv_q == 4'h8) [*3] ##0 host_tick_q ##1 hdiv_q == 4'h8
      |-> !host_tick_q ##1 host_tick_q)
    else $error("host divide by two wrong");
  host_high_a: assert property (
    hdiv_q == 4'hc |-> host_shift == 4'h6)
    else $error("host divide by 64 mapping wrong");
  low_pass_a: assert property (
    low_shift == 4'h0 && $past(low_shift) == 4'h0 && $past(host_tick_q)
      |-> low_tick_q)
    else $error("undivided low-speed tick missing");
  low_div_a: assert property (
    ldiv_q == 3'h7 |-> low_shift == 4'h4)
    else $error("low-speed divide by 16 mapping wrong");

  synth_switch_c: cover property (
    state_q == SW_LAND && sel_q == 2'h2 ##1 stat_q == 2'h2);
  fallback_c: cover property (fail_s_q && mon_en_q && fall_ev);
  read_wait_c: cover property (ar_full_q && !idle ##2 rvalid_q);
  byte_write_c: cover property (wr_cfg && w_strb_q == 4'h2);

endmodule

// ---- test/core_clock_select_bus_prescaler_test.sv ----
// self-checking bench for the clock select and bus divider block
// assumes scsbp_top with default address width, driven over axi4-lite
`timescale 1ns/10ps
`include "scsbp_params.svh"
module core_clock_select_bus_prescaler_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [2:0] prot = 3'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic low_power_exit = 1'b0;
  logic ext_osc_fail = 1'b0;
  logic synth_from_ext = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, core_clock_source;
  logic [31:0] rdata;
  logic host_bus_tick, low_speed_bus_tick;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  localparam logic [7:0] CFG = `SCSBP_CFG1_OFF;

  scsbp_top dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(prot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(prot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .low_power_exit(low_power_exit), .ext_osc_fail(ext_osc_fail),
    .synth_from_ext(synth_from_ext),
    .core_clock_source(core_clock_source),
    .host_bus_tick(host_bus_tick), .low_speed_bus_tick(low_speed_bus_tick)
  );

  always #4 aclk = ~aclk;

  task automatic print_verdict;
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a hang ends the run as a mismatch
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask

  // lat counts edges from the last handshake to bvalid seen high
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r, output int lat);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    lat = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && awready === 1'b1)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      lat++;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // cycles between two successive ticks
  task automatic per(input logic lo, output int p);
    p = 0;
    do @(posedge aclk); while ((lo ? low_speed_bus_tick : host_bus_tick) !== 1'b1);
    do
    begin
      @(posedge aclk);
      p++;
    end while ((lo ? low_speed_bus_tick : host_bus_tick) !== 1'b1);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    int lat;
    rd(CFG, d, r);
    chk("reset word", 32'h0000_0000, d);
    chk("reset source", 32'h0000_0000, 32'(core_clock_source));
    wr(CFG, 32'h0000_0000, 4'hf, r, lat);
    chk("idle write latency", 32'h0000_0002, 32'(lat));
  endtask

  task automatic t_host_div;
    logic [1:0] r;
    int lat, p, e;
    for (int c = 0; c < 16; c++)
    begin
      wr(CFG, 32'(c) << 4, 4'h1, r, lat);
      per(1'b0, p);
      e = c < 8 ? 1 : (c < 12 ? 2 << (c - 8) : 64 << (c - 12));
      chk("host ratio", 32'(e), 32'(p));
    end
    wr(CFG, 32'h0000_0000, 4'h1, r, lat);
  endtask

  task automatic t_low_div;
    logic [1:0] r;
    int lat, p;
    for (int c = 0; c < 8; c++)
    begin
      wr(CFG, 32'(c) << 8, 4'h2, r, lat);
      per(1'b1, p);
      chk("low ratio", 32'(c < 4 ? 1 : 2 << (c - 4)), 32'(p));
    end
    wr(CFG, 32'h0000_0000, 4'h2, r, lat);
  endtask

  task automatic t_select;
    logic [31:0] d;
    logic [1:0] r;
    int lat;
    wr(CFG, 32'h0000_0001, 4'h1, r, lat);
    wr(CFG, 32'h0000_0001, 4'h1, r, lat);
    chk("switch latency", 32'h0000_0001, 32'(lat <= 4));
    repeat (8) @(posedge aclk);
    rd(CFG, d, r);
    chk("ext selected", 32'h0000_0005, d);
    wr(CFG, 32'h0000_0003, 4'h1, r, lat);
    chk("code 11 resp", 32'h0000_0000, 32'(r));
    rd(CFG, d, r);
    chk("code 11 refused", 32'h0000_0005, d);
    wr(CFG, 32'h0000_0002, 4'h1, r, lat);
    chk("status lags", 32'h0000_0001, 32'(core_clock_source));
    repeat (8) @(posedge aclk);
    rd(CFG, d, r);
    chk("synth selected", 32'h0000_000a, d);
  endtask

  // raise a clock event, then expect the given configuration word
  task automatic ev(input logic lp, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    repeat (8) @(posedge aclk);
    if (lp)
      low_power_exit <= 1'b1;
    else
      ext_osc_fail <= 1'b1;
    repeat (10) @(posedge aclk);
    low_power_exit <= 1'b0;
    ext_osc_fail <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(CFG, d, r);
    chk("after clock event", e, d);
  endtask

  task automatic t_fallback;
    logic [1:0] r;
    int lat;
    wr(CFG, 32'h0000_0001, 4'h1, r, lat);
    ev(1'b0, 32'h0000_0005);
    wr(`SCSBP_MON_OFF, 32'h0000_0001, 4'h1, r, lat);
    ev(1'b0, 32'h0000_0000);
    synth_from_ext <= 1'b1;
    wr(CFG, 32'h0000_0002, 4'h1, r, lat);
    ev(1'b0, 32'h0000_0000);
    wr(CFG, 32'h0000_0001, 4'h1, r, lat);
    ev(1'b1, 32'h0000_0000);
  endtask

  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    int lat;
    rd(8'h80, d, r);
    chk("unmapped rresp", 32'(`SCSBP_RESP_SLVERR), 32'(r));
    wr(8'h80, 32'hffff_ffff, 4'hf, r, lat);
    chk("unmapped bresp", 32'(`SCSBP_RESP_SLVERR), 32'(r));
    wr(CFG, 32'hffff_f80c, 4'hf, r, lat);
    rd(CFG, d, r);
    chk("read-only bits", 32'h0000_0000, d);
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_host_div();
    t_low_div();
    t_select();
    t_fallback();
    t_unmapped();
    print_verdict();
  end
endmodule
